// [core/adtc_top.sv]
/*
 Converter front end control: clock divider, reference and channel select,
 precharge and acquisition timing, sample capacitance, repeat tally and results.
 Assumes an Avalon-MM master on CLK and a converter model on CONV_RESULT.
*/
// Register access over Avalon-MM was decided locally.
// Behaviour
// - Converter clock is oscillator over 2(n+1).
// - Divider ignored when RC oscillator selected.
// - Two-bit reference select; code 01 reserved.
// - Six-bit positive input channel multiplexer select.
// - Precharge lasts n clocks of chosen source.
// - Acquisition lasts n clocks of chosen source.
// - Zero acquisition means 8192, or skipped.
// - Five-bit added capacitance in picofarads.
// - Eight-bit trigger tally, readable, resets zero.
// - Threshold check when tally reaches target.
// - Averaging modes output shifted accumulator.
// - Low-pass mode outputs filter value.
// - Filtered output sixteen-bit signed, read only.
// - Sixteen-bit outcome register, bytewise, resets zero.
// - Timing fields split low and high bytes.
// - Stages precharge, acquisition, conversion; codes reported.
`timescale 1ns/10ps
`include "adtc_params.svh"
module adtc_top
#(
    parameter bit LARGE_PKG = 1'b1
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [15:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    output logic [1:0] RESPONSE,
    input wire logic [15:0] CONV_RESULT,
    output logic [2:0] STAGE,
    output logic [1:0] REF_SEL,
    output logic REF_VALID,
    output logic [5:0] CHAN_SEL,
    output logic CHAN_VALID,
    output logic [4:0] CAP_PF,
    output logic CONV_CLK_EN,
    output logic THRESH_CHECK
);
    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0] tally_ff;
    logic [7:0] rpt_ff;
    logic [15:0] outcome_ff;
    logic [15:0] prev_ff;
    logic [5:0] pch_ff;
    logic [12:0] acq_ff;
    logic [12:0] pre_ff;
    logic [4:0] cap_ff;
    logic [1:0] ref_ff;
    logic [5:0] div_ff;
    logic [7:0] ctrl_ff;
    logic [13:0] cnt_ff;
    logic [5:0] conv_cnt_ff;
    adtc_pkg::adtc_stage_e stage_ff;
    adtc_pkg::adtc_stage_e nxt_stage;
    logic [13:0] nxt_cnt;
    logic wreq_ff;
    logic [31:0] rdata_ff;
    logic [1:0] resp_ff;
    logic [2:0] stage_o_ff;
    logic ref_v_ff;
    logic chan_v_ff;
    logic conv_en_ff;
    logic thr_ff;
    logic [17:0] acc_w;
    logic [15:0] flt_w;

    adtc_tick_if tk();

    // ****************************************************************
    // Decoding.
    // ****************************************************************
    function automatic logic chan_ok(input logic [5:0] c, input logic big);
        logic ok;
        ok = 1'b0;
        if (c == 6'h16 || c == 6'h17 || (c >= 6'h0C && c <= 6'h0F))
            ok = big;
        else if (c >= 6'h10 && c <= 6'h15)
            ok = 1'b1;
        else if (c <= 6'h05)
            ok = 1'b1;
        else if (c == `ADTC_PCH_FVR2 || c == `ADTC_PCH_FVR1)
            ok = 1'b1;
        else if (c == `ADTC_PCH_TEMP || c == `ADTC_PCH_GND)
            ok = 1'b1;
        return ok;
    endfunction

    function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
        return hi ? v[15:8] : v[7:0];
    endfunction

    wire busy = (stage_ff != adtc_pkg::ST_IDLE);
    wire go = ctrl_ff[`ADTC_CTRL_GO];
    wire rc_sel = ctrl_ff[`ADTC_CTRL_RCSEL];
    wire [2:0] mode = ctrl_ff[`ADTC_CTRL_MODE_LSB +: 3];
    wire [2:0] shift = ctrl_ff[`ADTC_CTRL_SHIFT_LSB +: 3];
    wire req = (READ || WRITE) && wreq_ff;
    wire wr = WRITE && !wreq_ff;
    wire rd = READ && req;
    wire [15:0] a = ADDRESS >> 2;
    wire be0 = BYTEENABLE[0];
    wire [7:0] wd = WRITEDATA[7:0];
    wire conv_done = (stage_ff == adtc_pkg::ST_CONV) && tk.conv_tick
        && (conv_cnt_ff == `ADTC_CONV_CLOCKS);
    wire counting = (mode == adtc_pkg::MD_AVG) || (mode == adtc_pkg::MD_BURST)
        || (mode == adtc_pkg::MD_LPF);
    wire [13:0] acq_len = (acq_ff == 13'h0000) ? `ADTC_ACQ_DEFAULT : {1'b0, acq_ff};
    wire w_tally = wr && be0 && (a == `ADTC_IDX_TALLY);
    wire hit_check = counting && conv_done && (tally_ff + 8'h01 == rpt_ff);

    // ****************************************************************
    // Register reads.
    // ****************************************************************
    logic [7:0] rd_byte;
    logic mapped;
    always_comb
    begin
        rd_byte = 8'h00;
        mapped = 1'b1;
        case (a)
            `ADTC_IDX_FLT_LO: rd_byte = byte_of(flt_w, 1'b0);
            `ADTC_IDX_FLT_HI: rd_byte = byte_of(flt_w, 1'b1);
            `ADTC_IDX_TALLY: rd_byte = tally_ff;
            `ADTC_IDX_RPT: rd_byte = rpt_ff;
            `ADTC_IDX_PREV_LO: rd_byte = byte_of(prev_ff, 1'b0);
            `ADTC_IDX_PREV_HI: rd_byte = byte_of(prev_ff, 1'b1);
            `ADTC_IDX_OUT_LO: rd_byte = byte_of(outcome_ff, 1'b0);
            `ADTC_IDX_OUT_HI: rd_byte = byte_of(outcome_ff, 1'b1);
            `ADTC_IDX_PCH: rd_byte = {2'b00, pch_ff};
            `ADTC_IDX_ACQ_LO: rd_byte = acq_ff[7:0];
            `ADTC_IDX_ACQ_HI: rd_byte = {3'b000, acq_ff[12:8]};
            `ADTC_IDX_CAP: rd_byte = {3'b000, cap_ff};
            `ADTC_IDX_PRE_LO: rd_byte = pre_ff[7:0];
            `ADTC_IDX_PRE_HI: rd_byte = {3'b000, pre_ff[12:8]};
            `ADTC_IDX_REF: rd_byte = {6'h00, ref_ff};
            `ADTC_IDX_CLK: rd_byte = {2'b00, div_ff};
            `ADTC_IDX_CTRL: rd_byte = ctrl_ff;
            `ADTC_IDX_STAT: rd_byte = {5'h00, stage_ff};
            `ADTC_IDX_ACC_LO: rd_byte = acc_w[7:0];
            `ADTC_IDX_ACC_HI: rd_byte = acc_w[15:8];
            default: mapped = 1'b0;
        endcase
    end

    // Answer one cycle after the request; a write lands at the edge that ends the answer cycle.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wreq_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
            resp_ff <= 2'h0;
        end
        else
        begin
            wreq_ff <= !req;
            rdata_ff <= rd ? {24'h000000, rd_byte} : 32'h00000000;
            resp_ff <= (req && !mapped) ? 2'h2 : 2'h0;
        end
    end

    // ****************************************************************
    // Configuration writes.
    // ****************************************************************
    // split byte access
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rpt_ff <= 8'h00;
            pch_ff <= 6'h00;
            acq_ff <= 13'h0000;
            pre_ff <= 13'h0000;
            cap_ff <= 5'h00;
            ref_ff <= 2'h0;
            div_ff <= 6'h00;
        end
        else if (wr && be0)
        begin
            if (a == `ADTC_IDX_RPT)
                rpt_ff <= wd;
            if (a == `ADTC_IDX_PCH)
                pch_ff <= wd[5:0];
            if (a == `ADTC_IDX_ACQ_LO)
                acq_ff[7:0] <= wd;
            if (a == `ADTC_IDX_ACQ_HI)
                acq_ff[12:8] <= wd[4:0];
            if (a == `ADTC_IDX_PRE_LO)
                pre_ff[7:0] <= wd;
            if (a == `ADTC_IDX_PRE_HI)
                pre_ff[12:8] <= wd[4:0];
            if (a == `ADTC_IDX_CAP)
                cap_ff <= wd[4:0];
            if (a == `ADTC_IDX_REF)
                ref_ff <= wd[1:0];
            if (a == `ADTC_IDX_CLK)
                div_ff <= wd[5:0];
        end
    end

    // The go bit drops by hardware when a conversion ends; that beats a software write.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ctrl_ff <= `ADTC_CTRL_RST;
        else if (conv_done)
            ctrl_ff[`ADTC_CTRL_GO] <= 1'b0;
        else if (wr && be0 && a == `ADTC_IDX_CTRL)
            ctrl_ff <= wd;
    end

    // ****************************************************************
    // Results and tally.
    // ****************************************************************
    // outcome bytes
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            outcome_ff <= 16'h0000;
            prev_ff <= 16'h0000;
        end
        else if (conv_done)
            outcome_ff <= CONV_RESULT;
        else if (!busy && go)
            prev_ff <= outcome_ff;
        else if (wr && be0 && a == `ADTC_IDX_OUT_LO)
            outcome_ff[7:0] <= wd;
        else if (wr && be0 && a == `ADTC_IDX_OUT_HI)
            outcome_ff[15:8] <= wd;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            tally_ff <= 8'h00;
        else if (counting && conv_done)
            tally_ff <= hit_check ? 8'h00 : tally_ff + 8'h01;
        else if (w_tally)
            tally_ff <= wd;
    end

    // ****************************************************************
    // Stage sequencer.
    // ****************************************************************
    always_comb
    begin
        nxt_stage = stage_ff;
        nxt_cnt = cnt_ff;
        case (stage_ff)
            adtc_pkg::ST_IDLE:
            begin
                if (go && pre_ff != 13'h0000)
                begin
                    nxt_stage = adtc_pkg::ST_PRE;
                    nxt_cnt = {1'b0, pre_ff};
                end
                else if (go && acq_ff != 13'h0000)
                begin
                    nxt_stage = adtc_pkg::ST_ACQ;
                    nxt_cnt = {1'b0, acq_ff};
                end
                else if (go)
                    nxt_stage = adtc_pkg::ST_CONV;
            end
            adtc_pkg::ST_PRE:
            begin
                if (tk.stage_tick)
                    nxt_cnt = cnt_ff - 14'h0001;
                if (tk.stage_tick && cnt_ff == 14'h0001)
                begin
                    nxt_stage = adtc_pkg::ST_ACQ;
                    nxt_cnt = acq_len;
                end
            end
            adtc_pkg::ST_ACQ:
            begin
                if (tk.stage_tick)
                    nxt_cnt = cnt_ff - 14'h0001;
                if (tk.stage_tick && cnt_ff == 14'h0001)
                    nxt_stage = adtc_pkg::ST_CONV;
            end
            adtc_pkg::ST_CONV:
            begin
                if (conv_done)
                    nxt_stage = adtc_pkg::ST_IDLE;
            end
            default: nxt_stage = adtc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            stage_ff <= adtc_pkg::ST_IDLE;
            cnt_ff <= 14'h0000;
            conv_cnt_ff <= 6'h00;
        end
        else
        begin
            stage_ff <= nxt_stage;
            cnt_ff <= nxt_cnt;
            if (stage_ff != adtc_pkg::ST_CONV)
                conv_cnt_ff <= 6'h00;
            else if (tk.conv_tick)
                conv_cnt_ff <= conv_cnt_ff + 6'h01;
        end
    end

    // ****************************************************************
    // Submodules.
    // ****************************************************************
    // clock divider
    adtc_clkgen u_clk
    (
        .clk(CLK),
        .resetn(RESETN),
        .run(busy),
        .rc_sel(rc_sel),
        .div(div_ff),
        .tk(tk)
    );

    adtc_filter u_flt
    (
        .clk(CLK),
        .resetn(RESETN),
        .done(conv_done),
        .clr(wr && be0 && a == `ADTC_IDX_ACC_LO && !busy),
        .mode(mode),
        .shift(shift),
        .sample(CONV_RESULT),
        .acc(acc_w),
        .flt(flt_w)
    );

    // ****************************************************************
    // Registered outputs.
    // ****************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            stage_o_ff <= 3'b000;
            ref_v_ff <= 1'b1;
            chan_v_ff <= 1'b1;
            conv_en_ff <= 1'b0;
            thr_ff <= 1'b0;
        end
        else
        begin
            stage_o_ff <= nxt_stage;
            ref_v_ff <= (ref_ff != `ADTC_REF_RSVD);
            chan_v_ff <= chan_ok(pch_ff, LARGE_PKG);
            conv_en_ff <= (stage_ff == adtc_pkg::ST_CONV) && tk.conv_tick;
            thr_ff <= hit_check;
        end
    end

    assign READDATA = rdata_ff;
    assign WAITREQUEST = wreq_ff;
    assign RESPONSE = resp_ff;
    assign STAGE = stage_o_ff;
    assign REF_SEL = ref_ff;
    assign REF_VALID = ref_v_ff;
    assign CHAN_SEL = pch_ff;
    assign CHAN_VALID = chan_v_ff;
    assign CAP_PF = cap_ff;
    assign CONV_CLK_EN = conv_en_ff;
    assign THRESH_CHECK = thr_ff;
endmodule

// [pkg/adtc_params.svh]
/*
 Constants of the converter timing and channel register block: byte addresses,
 field positions, reset values, counts and channel codes.
 Assumes inclusion by bare name from any file that needs them.
*/
`ifndef ADTC_PARAMS_SVH
`define ADTC_PARAMS_SVH

// ****************************************************************
// Printed byte offsets, kept as register indices.
// ****************************************************************
`define ADTC_IDX_FLT_LO 16'h1D14
`define ADTC_IDX_FLT_HI 16'h1D15
`define ADTC_IDX_TALLY 16'h1D19
`define ADTC_IDX_RPT 16'h1D1A
`define ADTC_IDX_PREV_LO 16'h1D1B
`define ADTC_IDX_PREV_HI 16'h1D1C
`define ADTC_IDX_OUT_LO 16'h1D1D
`define ADTC_IDX_OUT_HI 16'h1D1E
`define ADTC_IDX_PCH 16'h1D1F
`define ADTC_IDX_ACQ_LO 16'h1D21
`define ADTC_IDX_ACQ_HI 16'h1D22
`define ADTC_IDX_CAP 16'h1D23
`define ADTC_IDX_PRE_LO 16'h1D24
`define ADTC_IDX_PRE_HI 16'h1D25
`define ADTC_IDX_REF 16'h1D2B
`define ADTC_IDX_CLK 16'h1D2D
// Own control and status registers.
`define ADTC_IDX_CTRL 16'h1D40
`define ADTC_IDX_STAT 16'h1D41
`define ADTC_IDX_ACC_LO 16'h1D42
`define ADTC_IDX_ACC_HI 16'h1D43

// ****************************************************************
// Control register fields.
// ****************************************************************
`define ADTC_CTRL_GO 0
`define ADTC_CTRL_RCSEL 1
`define ADTC_CTRL_MODE_LSB 2
`define ADTC_CTRL_SHIFT_LSB 5
`define ADTC_CTRL_RST 8'h00

// ****************************************************************
// Codes and counts.
// ****************************************************************
`define ADTC_ACQ_DEFAULT 14'h2000
`define ADTC_CONV_CLOCKS 6'h0B
`define ADTC_RC_DIV 8'h03
`define ADTC_REF_RSVD 2'h1
`define ADTC_PCH_FVR2 6'h3F
`define ADTC_PCH_FVR1 6'h3E
`define ADTC_PCH_TEMP 6'h3B
`define ADTC_PCH_GND 6'h3A
`define ADTC_PCH_GROUP 6'h03

`endif

// [pkg/adtc_pkg.sv]
/*
 Types of the converter timing and channel register block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adtc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_ACQ = 3'b010,
        ST_CONV = 3'b011
    } adtc_stage_e;

    typedef enum logic [2:0] {
        MD_BASIC = 3'b000,
        MD_ACCUM = 3'b001,
        MD_AVG = 3'b010,
        MD_BURST = 3'b011,
        MD_LPF = 3'b100
    } adtc_mode_e;
endpackage

// [pkg/adtc_tick_if.sv]
/*
 Interface carrying timing ticks from the clock source module to the core.
 Assumes one clock domain.
*/
`timescale 1ns/10ps
interface adtc_tick_if;
    logic stage_tick;
    logic conv_tick;
    modport src (output stage_tick, output conv_tick);
    modport snk (input stage_tick, input conv_tick);
endinterface

// [core/adtc_clkgen.sv]
/*
 Tick generator: stage timing ticks and converter clock enables.
 Assumes CLK is the system oscillator; the RC oscillator is modelled by a fixed divider.
*/
`timescale 1ns/10ps
`include "adtc_params.svh"
module adtc_clkgen
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic rc_sel,
    input wire logic [5:0] div,
    adtc_tick_if.src tk
);
    logic [6:0] div_cnt_ff;
    logic [7:0] rc_cnt_ff;
    wire div_end = (div_cnt_ff == {div, 1'b1});
    wire rc_end = (rc_cnt_ff == `ADTC_RC_DIV);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            div_cnt_ff <= 7'h00;
        else if (!run || div_end)
            div_cnt_ff <= 7'h00;
        else
            div_cnt_ff <= div_cnt_ff + 7'h01;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rc_cnt_ff <= 8'h00;
        else if (!run || rc_end)
            rc_cnt_ff <= 8'h00;
        else
            rc_cnt_ff <= rc_cnt_ff + 8'h01;
    end

    // Stage time counts oscillator clocks, or RC clocks when RC is chosen.
    assign tk.stage_tick = rc_sel ? rc_end : 1'b1;
    // The divider acts only with the system oscillator as source.
    assign tk.conv_tick = rc_sel ? rc_end : div_end;
endmodule

// [core/adtc_filter.sv]
/*
 Computation unit: accumulator and filtered output.
 Assumes one strobe per finished conversion with its result.
*/
`timescale 1ns/10ps
`include "adtc_params.svh"
module adtc_filter
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic done,
    input wire logic clr,
    input wire logic [2:0] mode,
    input wire logic [2:0] shift,
    input wire logic [15:0] sample,
    output logic [17:0] acc,
    output logic [15:0] flt
);
    logic [17:0] acc_ff;
    logic [15:0] flt_ff;
    wire signed [17:0] acc_s = acc_ff;
    wire signed [17:0] smp_s = {2'b00, sample};
    wire signed [17:0] nxt_acc = (mode == adtc_pkg::MD_LPF)
        ? acc_s - (acc_s >>> shift) + smp_s : acc_s + smp_s;
    wire signed [17:0] shifted = nxt_acc >>> shift;
    wire basic = (mode == adtc_pkg::MD_BASIC);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            acc_ff <= 18'h00000;
        else if (clr)
            acc_ff <= 18'h00000;
        else if (done && !basic)
            acc_ff <= nxt_acc;
    end

    // Accumulating modes show the shifted sum; the low-pass mode shows its filter state shifted the same way.
    always_ff @(posedge clk)
    begin
        if (done && !basic)
            flt_ff <= shifted[15:0];
    end

    assign acc = acc_ff;
    assign flt = flt_ff;
endmodule

// [dv/adtc_assertions.sv]
/*
 Port checker of the converter timing and channel register block.
 Assumes it is bound to adtc_top and that adtc_pkg is compiled first.
*/
`timescale 1ns/10ps
module adtc_assertions
#(
    parameter bit LARGE_PKG = 1'b1
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [15:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    input wire logic [1:0] RESPONSE,
    input wire logic [2:0] STAGE,
    input wire logic [1:0] REF_SEL,
    input wire logic REF_VALID,
    input wire logic [5:0] CHAN_SEL,
    input wire logic CHAN_VALID,
    input wire logic CONV_CLK_EN,
    input wire logic THRESH_CHECK
);
    wire logic [15:0] idx = {2'h0, ADDRESS[15:2]};
    wire logic mapped = idx inside {[16'h1D14:16'h1D15], [16'h1D19:16'h1D1F],
        [16'h1D21:16'h1D25], 16'h1D2B, 16'h1D2D, [16'h1D40:16'h1D43]};
    // Pins that exist only on the larger package variant.
    wire logic pin_big = CHAN_SEL inside {[6'h0C:6'h0F], [6'h16:6'h17]};
    wire logic chan_ok = (CHAN_SEL inside {[6'h00:6'h05], [6'h10:6'h15], [6'h3A:6'h3B],
        [6'h3E:6'h3F]}) || (LARGE_PKG && pin_big);

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence req_s;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence left_s(logic [2:0] s);
        STAGE == s ##1 STAGE != s;
    endsequence

    // ********************
    // Bus answers.
    // ********************
    AST_ANSWER: assert property (req_s |=> !WAITREQUEST && RESPONSE == ($past(mapped) ? 2'h0 : 2'h2))
        else $error("bus answer late or with wrong response");
    AST_ONE_CYCLE: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("answer stood longer than one cycle");
    AST_UNMAPPED_ZERO: assert property (!WAITREQUEST && RESPONSE == 2'h2 |-> READDATA == 32'h0)
        else $error("unmapped access returned data");

    // ********************
    // Selects and stages.
    // ********************
    AST_REF_VALID: assert property ($stable(REF_SEL) [*2] |-> REF_VALID == (REF_SEL != 2'h1))
        else $error("reference valid flag wrong");
    AST_CHAN_VALID: assert property ($stable(CHAN_SEL) [*2] |-> CHAN_VALID == chan_ok)
        else $error("channel valid flag wrong");
    AST_PRE_NEXT: assert property (left_s(adtc_pkg::ST_PRE) |-> STAGE == adtc_pkg::ST_ACQ)
        else $error("precharge not followed by acquisition");
    AST_ACQ_NEXT: assert property (left_s(adtc_pkg::ST_ACQ) |-> STAGE == adtc_pkg::ST_CONV)
        else $error("acquisition not followed by conversion");
    AST_CONV_NEXT: assert property (left_s(adtc_pkg::ST_CONV) |-> STAGE == adtc_pkg::ST_IDLE)
        else $error("conversion not followed by idle");
    AST_IDLE_QUIET: assert property (STAGE == adtc_pkg::ST_IDLE [*3] |-> !CONV_CLK_EN)
        else $error("converter clock running while idle");
    AST_THRESH_PULSE: assert property (THRESH_CHECK |=> !THRESH_CHECK)
        else $error("threshold check pulse too long");
endmodule

bind adtc_top adtc_assertions #(.LARGE_PKG(LARGE_PKG)) i_chk (.CLK(CLK), .RESETN(RESETN),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .RESPONSE(RESPONSE), .STAGE(STAGE), .REF_SEL(REF_SEL),
    .REF_VALID(REF_VALID), .CHAN_SEL(CHAN_SEL), .CHAN_VALID(CHAN_VALID),
    .CONV_CLK_EN(CONV_CLK_EN), .THRESH_CHECK(THRESH_CHECK));

// [dv/testbench.sv]
/*
 Self-checking bench of the converter timing and channel register block.
 Assumes the package, interface, design and checker are compiled before it.
*/
`timescale 1ns/10ps
module testbench;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [15:0] ADDRESS = 16'h0;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [3:0] BYTEENABLE = 4'hF;
    logic [15:0] CONV_RESULT = 16'h0;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic [1:0] RESPONSE;
    logic [2:0] STAGE;
    logic [1:0] REF_SEL;
    logic REF_VALID;
    logic [5:0] CHAN_SEL;
    logic CHAN_VALID;
    logic [4:0] CAP_PF;
    logic CONV_CLK_EN;
    logic THRESH_CHECK;
    int mismatches = 0;
    int samples_checked = 0;
    int cnt [4];
    int pulses, gap, last, tick, thr;
    logic [31:0] q;
    logic [1:0] resp;
    logic [15:0] r_idx [12] = '{16'h1D19, 16'h1D1A, 16'h1D1D, 16'h1D1E, 16'h1D1F, 16'h1D21,
        16'h1D22, 16'h1D23, 16'h1D24, 16'h1D25, 16'h1D2B, 16'h1D2D};
    logic [7:0] r_val [12] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h15, 8'h81, 8'h1F, 8'h1F, 8'h7E,
        8'h10, 8'h03, 8'h3F};
    logic [5:0] ch_code [10] = '{6'h3F, 6'h3E, 6'h3B, 6'h3A, 6'h03, 6'h00, 6'h17, 6'h0C, 6'h3C,
        6'h20};
    logic [9:0] ch_ok = 10'h0FF;
    // Rows: precharge, acquisition, divider, control, then expected counts and pulse gap.
    logic [12:0] t_pre [5] = '{13'h0103, 13'h0002, 13'h0000, 13'h0000, 13'h0001};
    logic [12:0] t_acq [5] = '{13'h0002, 13'h0001, 13'h0002, 13'h0000, 13'h0000};
    logic [7:0] t_div [5] = '{8'h01, 8'h05, 8'h00, 8'h00, 8'h02};
    logic [7:0] t_ctl [5] = '{8'h01, 8'h03, 8'h01, 8'h01, 8'h01};
    int t_u [5] = '{1, 4, 1, 1, 1};
    int t_epre [5] = '{259, 2, 0, 0, 1};
    int t_eacq [5] = '{2, 1, 2, 0, 8192};
    int t_gap [5] = '{4, 4, 2, 2, 6};

    adtc_top i_dut (.CLK, .RESETN, .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
        .WAITREQUEST, .RESPONSE, .CONV_RESULT, .STAGE, .REF_SEL, .REF_VALID, .CHAN_SEL,
        .CHAN_VALID, .CAP_PF, .CONV_CLK_EN, .THRESH_CHECK);

    initial forever #4 CLK = ~CLK;

    // Stage lengths and converter clock spacing are measured off the ports.
    always @(posedge CLK)
    begin
        #1;
        tick++;
        if (STAGE != 3'h0)
            cnt[STAGE[1:0]]++;
        if (CONV_CLK_EN === 1'b1)
        begin
            pulses++;
            gap = tick - last;
            last = tick;
        end
        if (THRESH_CHECK === 1'b1)
            thr++;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        ADDRESS <= {idx[13:0], 2'h0};
        READ <= !wr;
        WRITE <= wr;
        WRITEDATA <= {24'h0, d};
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (WAITREQUEST !== 1'b0 && n < 50);
        if (n >= 50)
            mismatches++;
        q = READDATA;
        resp = RESPONSE;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask

    task conv(input logic [7:0] ctl, input logic [15:0] res);
        int n;
        n = 0;
        cnt = '{0, 0, 0, 0};
        pulses = 0;
        CONV_RESULT <= res;
        bus(1'b1, 16'h1D40, ctl);
        do
        begin
            @(posedge CLK);
            #2;
            n++;
        end
        while (n < 20000 && (STAGE !== 3'h0 || cnt[3] == 0));
        if (n >= 20000)
            mismatches++;
        check("conv clocks", pulses, 12);
    endtask

    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // A hang is cut off well after the longest expected run.
    initial
    begin
        #480000;
        mismatches++;
        test_done();
    end

    initial
    begin
        repeat (3) @(posedge CLK);
        RESETN <= 1'b1;
        bus(1'b0, 16'h1D19, 8'h0);
        check("tally reset", q, 32'h0);
        bus(1'b0, 16'h1D1E, 8'h0);
        check("outcome reset", q, 32'h0);
        bus(1'b0, 16'h1D30, 8'h0);
        check("unmapped resp", resp, 2'h2);
        check("unmapped data", q, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            bus(1'b1, r_idx[i], r_val[i]);
            bus(1'b0, r_idx[i], 8'h0);
            check("readback", q, {24'h0, r_val[i]});
            check("response", resp, 2'h0);
        end
        check("cap pins", CAP_PF, 5'h1F);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 16'h1D2B, 8'(i));
            repeat (2) @(posedge CLK);
            check("ref code", REF_SEL, i[1:0]);
            check("ref valid", REF_VALID, i != 1);
        end
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b1, 16'h1D1F, {2'h0, ch_code[i]});
            repeat (2) @(posedge CLK);
            check("chan code", CHAN_SEL, ch_code[i]);
            check("chan valid", CHAN_VALID, ch_ok[i]);
        end
        $display("register test done");
        // zero lengths are rows of the table.
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, 16'h1D24, t_pre[i][7:0]);
            bus(1'b1, 16'h1D25, {3'h0, t_pre[i][12:8]});
            bus(1'b1, 16'h1D21, t_acq[i][7:0]);
            bus(1'b1, 16'h1D22, {3'h0, t_acq[i][12:8]});
            bus(1'b1, 16'h1D2D, t_div[i]);
            conv(t_ctl[i], 16'hA5C0 + 16'(i));
            check("precharge", (cnt[1] + t_u[i] - 1) / t_u[i], t_epre[i]);
            check("acquisition", (cnt[2] + t_u[i] - 1) / t_u[i], t_eacq[i]);
            check("conv gap", gap, t_gap[i]);
            bus(1'b0, 16'h1D1D, 8'h0);
            check("outcome lo", q, {24'h0, 8'hC0 + 8'(i)});
            bus(1'b0, 16'h1D1E, 8'h0);
            check("outcome hi", q, 32'hA5);
        end
        $display("timing test done");
        bus(1'b1, 16'h1D24, 8'h0);
        bus(1'b1, 16'h1D19, 8'h0);
        bus(1'b1, 16'h1D1A, 8'h2);
        bus(1'b1, 16'h1D42, 8'h0);
        thr = 0;
        conv(8'h29, 16'h0010);
        bus(1'b0, 16'h1D19, 8'h0);
        check("tally one", q, 32'h1);
        check("early check", thr, 0);
        conv(8'h29, 16'h0030);
        check("threshold", thr, 1);
        bus(1'b0, 16'h1D19, 8'h0);
        check("tally wrap", q, 32'h0);
        bus(1'b1, 16'h1D14, 8'hFF);
        bus(1'b0, 16'h1D14, 8'h0);
        check("filter lo", q, 32'h20);
        bus(1'b0, 16'h1D15, 8'h0);
        check("filter hi", q, 32'h0);
        $display("average test done");
        test_done();
    end
endmodule
